// >>> core/fetch_map.sv
// Program-fetch sequencer and data-space map of an 8-bit controller.
// Assumes an APB master and a combinational on-chip ROM on core_clk_i;
// strap, port pins and the muxed bus come from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module fetch_map (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        external_code_strap_i,
    output logic      [11:0] rom_addr_o,
    input  wire logic [7:0]  rom_data_i,
    input  wire logic [7:0]  muxed_addr_data_port_i,
    output logic      [7:0]  muxed_addr_data_port_o,
    output logic             muxed_addr_data_port_oe_o,
    output logic             addr_latch_strobe_o,
    output logic             code_read_strobe_n_o,
    output logic      [7:0]  high_addr_port_o,
    input  wire logic [7:0]  port_pin_i,
    output logic      [7:0]  port_latch_o
);
    typedef struct packed {
        fetch_map_pkg::fetch_state_t st;
        logic [1:0]        cnt;
        logic              pend;
        logic [15:0]       pc;
        logic [7:0]        code;
        logic              ext_src;
        logic [7:0]        mux_out;
        logic              mux_oe;
        logic              latch;
        logic              strobe_n;
        logic [7:0]        high;
        logic [1:0]        strap_s;
        logic [7:0]        pin_s1;
        logic [7:0]        pin_s2;
        logic [7:0]        dat_s1;
        logic [7:0]        dat_s2;
        logic [13:0]       dadr;
        logic [7:0]        sp;
        logic [7:0]        program_status_word;
        logic [7:0]        data_pointer_low;
        logic [7:0]        data_pointer_high;
        logic [7:0]        tl0;
        logic [7:0]        th0;
        logic [7:0]        tl1;
        logic [7:0]        th1;
        logic [7:0]        ip;
        logic [7:0]        plat;
        logic [1:0]        trun;
        logic [31:0]       rdata;
        logic [127:0][7:0] ram;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic   setup;
    logic   access;
    logic   wr;

    // Working address: bank registers fold in the status-word bank bits
    function automatic logic [7:0] eff_addr(input state_t s);
        if (s.dadr[fetch_map_pkg::DA_REG]) begin
            eff_addr = {3'b000, s.program_status_word[fetch_map_pkg::PSW_BANK +: 2],
                        s.dadr[2:0]};
        end else begin
            eff_addr = s.dadr[7:0];
        end
    endfunction

    // Upper half is special space only when addressed directly
    function automatic logic is_sfr(input state_t s);
        is_sfr = eff_addr(s) >= fetch_map_pkg::SFR_BASE &&
                 !s.dadr[fetch_map_pkg::DA_IND];
    endfunction

    // Byte read of the data space; empty slots read zero
    function automatic logic [7:0] rd_space(input state_t s);
        logic [7:0] a;
        a = eff_addr(s);
        rd_space = 8'h00;
        if (!a[7]) begin
            rd_space = s.ram[a[6:0]];
        end else if (is_sfr(s)) begin
            case (a)
                fetch_map_pkg::SFR_SP:   rd_space = s.sp;
                fetch_map_pkg::SFR_DPL:  rd_space = s.data_pointer_low;
                fetch_map_pkg::SFR_DPH:  rd_space = s.data_pointer_high;
                fetch_map_pkg::SFR_TL0:  rd_space = s.tl0;
                fetch_map_pkg::SFR_TH0:  rd_space = s.th0;
                fetch_map_pkg::SFR_TL1:  rd_space = s.tl1;
                fetch_map_pkg::SFR_TH1:  rd_space = s.th1;
                fetch_map_pkg::SFR_PORT: rd_space = s.pin_s2;
                fetch_map_pkg::SFR_IP:   rd_space = s.ip;
                fetch_map_pkg::SFR_PSW:  rd_space = s.program_status_word;
                default:                 rd_space = 8'h00;
            endcase
        end
    endfunction

    // Single-bit access only on special addresses ending in 0 or 8
    function automatic logic bit_ok(input state_t s);
        bit_ok = is_sfr(s) && eff_addr(s)[2:0] == 3'b000;
    endfunction

    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign wr     = access && pwrite_i;

    // Next-state logic for bus, data space and fetch sequencer
    always_comb begin
        logic [7:0]  wv;
        logic [7:0]  a;
        logic [15:0] t0;
        logic [15:0] t1;
        logic        idle;
        wv = 8'h00;
        a = 8'h00;
        state_d = state_q;
        idle = state_q.st == fetch_map_pkg::S_IDLE && !state_q.pend;
        // Two-stage synchronisers for everything from the pins
        state_d.strap_s = {state_q.strap_s[0], external_code_strap_i};
        state_d.pin_s1 = port_pin_i;
        state_d.pin_s2 = state_q.pin_s1;
        state_d.dat_s1 = muxed_addr_data_port_i;
        state_d.dat_s2 = state_q.dat_s1;
        // Timers count every cycle while their run bit is set
        t0 = {state_q.th0, state_q.tl0} + 16'h0001;
        t1 = {state_q.th1, state_q.tl1} + 16'h0001;
        if (state_q.trun[0]) begin
            {state_d.th0, state_d.tl0} = t0;
        end
        if (state_q.trun[1]) begin
            {state_d.th1, state_d.tl1} = t1;
        end
        // Register writes land on the access edge
        if (wr) begin
            case (paddr_i)
                fetch_map_pkg::OFS_CTRL: begin
                    state_d.trun = pwdata_i[fetch_map_pkg::CTRL_TRUN +: 2];
                    if (pwdata_i[fetch_map_pkg::CTRL_START] && idle) begin
                        state_d.pend = 1'b1;
                    end
                end
                fetch_map_pkg::OFS_FADDR: begin
                    if (idle) begin
                        state_d.pc = pwdata_i[15:0];
                    end
                end
                fetch_map_pkg::OFS_VECT: begin
                    if (idle && pwdata_i[2:0] < fetch_map_pkg::VEC_COUNT) begin
                        state_d.pc = fetch_map_pkg::VEC_BASE +
                            16'(pwdata_i[2:0]) * fetch_map_pkg::VEC_STEP;
                        state_d.pend = 1'b1;
                    end
                end
                fetch_map_pkg::OFS_DADR: begin
                    state_d.dadr = pwdata_i[13:0];
                end
                fetch_map_pkg::OFS_DDAT: begin
                    a = eff_addr(state_q);
                    wv = pwdata_i[7:0];
                    if (state_q.dadr[fetch_map_pkg::DA_BIT]) begin
                        wv = rd_space(state_q);
                        wv[state_q.dadr[fetch_map_pkg::DA_POS +: 3]] =
                            pwdata_i[0];
                    end
                    if (!state_q.dadr[fetch_map_pkg::DA_BIT] ||
                        bit_ok(state_q)) begin
                        if (!a[7]) begin
                            state_d.ram[a[6:0]] = wv;
                        end else if (is_sfr(state_q)) begin
                            // Empty special slots hold nothing
                            case (a)
                                fetch_map_pkg::SFR_SP:   state_d.sp = wv;
                                fetch_map_pkg::SFR_DPL:  state_d.data_pointer_low = wv;
                                fetch_map_pkg::SFR_DPH:  state_d.data_pointer_high = wv;
                                fetch_map_pkg::SFR_TL0:  state_d.tl0 = wv;
                                fetch_map_pkg::SFR_TH0:  state_d.th0 = wv;
                                fetch_map_pkg::SFR_TL1:  state_d.tl1 = wv;
                                fetch_map_pkg::SFR_TH1:  state_d.th1 = wv;
                                fetch_map_pkg::SFR_PORT: state_d.plat = wv;
                                fetch_map_pkg::SFR_IP:
                                    state_d.ip = wv & fetch_map_pkg::IP_USED;
                                fetch_map_pkg::SFR_PSW:  state_d.program_status_word = wv;
                                default:                 state_d.program_status_word = state_d.program_status_word;
                            endcase
                        end
                    end
                end
                fetch_map_pkg::OFS_PUSH: begin
                    // Pre-increment, so the first push lands one above reset
                    state_d.sp = state_q.sp + 8'h01;
                    state_d.ram[state_d.sp[6:0]] = pwdata_i[7:0];
                end
                fetch_map_pkg::OFS_DATA_POINTER_PAIR: begin
                    {state_d.data_pointer_high, state_d.data_pointer_low} = pwdata_i[15:0];
                end
                default: begin
                    state_d.dadr = state_q.dadr;
                end
            endcase
        end
        // Fetch sequencer
        case (state_q.st)
            fetch_map_pkg::S_IDLE: begin
                if (state_q.pend) begin
                    state_d.pend = 1'b0;
                    state_d.high = state_q.pc[15:8];
                    if (state_q.strap_s[1] &&
                        state_q.pc <= fetch_map_pkg::INT_ROM_TOP) begin
                        state_d.st = fetch_map_pkg::S_INT;
                    end else begin
                        state_d.st = fetch_map_pkg::S_ALE;
                        state_d.mux_out = state_q.pc[7:0];
                        state_d.mux_oe = 1'b1;
                        state_d.latch = 1'b1;
                    end
                end
            end
            fetch_map_pkg::S_INT: begin
                state_d.code = rom_data_i;
                state_d.ext_src = 1'b0;
                state_d.st = fetch_map_pkg::S_IDLE;
            end
            fetch_map_pkg::S_ALE: begin
                // Address held one more cycle past the latch edge
                state_d.latch = 1'b0;
                state_d.st = fetch_map_pkg::S_ADR;
            end
            fetch_map_pkg::S_ADR: begin
                state_d.mux_oe = 1'b0;
                state_d.strobe_n = 1'b0;
                state_d.cnt = 2'h0;
                state_d.st = fetch_map_pkg::S_STB;
            end
            fetch_map_pkg::S_STB: begin
                // Waits out the pin synchroniser before sampling
                if (state_q.cnt == fetch_map_pkg::STRB_WAIT - 2'h1) begin
                    state_d.st = fetch_map_pkg::S_SMP;
                end else begin
                    state_d.cnt = state_q.cnt + 2'h1;
                end
            end
            fetch_map_pkg::S_SMP: begin
                state_d.code = state_q.dat_s2;
                state_d.ext_src = 1'b1;
                state_d.strobe_n = 1'b1;
                state_d.st = fetch_map_pkg::S_IDLE;
            end
            default: begin
                state_d.st = fetch_map_pkg::S_IDLE;
            end
        endcase
        // Read data is prepared in the setup cycle
        if (setup) begin
            case (paddr_i)
                fetch_map_pkg::OFS_CTRL:
                    state_d.rdata = {29'h0, state_q.trun, 1'b0};
                fetch_map_pkg::OFS_FADDR:
                    state_d.rdata = {16'h0000, state_q.pc};
                fetch_map_pkg::OFS_STAT:
                    state_d.rdata = {21'h0, state_q.strap_s[1],
                                     state_q.ext_src, !idle, state_q.code};
                fetch_map_pkg::OFS_DADR:
                    state_d.rdata = {18'h0, state_q.dadr};
                fetch_map_pkg::OFS_DDAT: begin
                    wv = rd_space(state_q);
                    state_d.rdata = {24'h00_0000, wv};
                    if (state_q.dadr[fetch_map_pkg::DA_BIT]) begin
                        state_d.rdata = {31'h0, bit_ok(state_q) &&
                            wv[state_q.dadr[fetch_map_pkg::DA_POS +: 3]]};
                    end
                end
                fetch_map_pkg::OFS_PUSH:
                    state_d.rdata = {24'h00_0000, state_q.sp};
                fetch_map_pkg::OFS_DATA_POINTER_PAIR:
                    state_d.rdata = {16'h0000, state_q.data_pointer_high, state_q.data_pointer_low};
                fetch_map_pkg::OFS_TIMR:
                    state_d.rdata = {state_q.th1, state_q.tl1,
                                     state_q.th0, state_q.tl0};
                default:
                    state_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; reset arms the first fetch at address zero
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q          <= '0;
            state_q.pc       <= fetch_map_pkg::RESET_PC;
            state_q.pend     <= 1'b1;
            state_q.strobe_n <= 1'b1;
            state_q.sp       <= fetch_map_pkg::SP_RESET;
            state_q.program_status_word      <= fetch_map_pkg::PSW_RESET;
            state_q.plat     <= fetch_map_pkg::PLAT_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs; the bus always answers in the access cycle
    assign pready_o   = 1'b1;
    assign pslverr_o  = access && (paddr_i > fetch_map_pkg::OFS_TIMR ||
                                   paddr_i[1:0] != 2'b00);
    assign prdata_o   = state_q.rdata;
    assign rom_addr_o = state_q.pc[11:0];
    assign muxed_addr_data_port_o    = state_q.mux_out;
    assign muxed_addr_data_port_oe_o = state_q.mux_oe;
    assign addr_latch_strobe_o       = state_q.latch;
    assign code_read_strobe_n_o      = state_q.strobe_n;
    assign high_addr_port_o          = state_q.high;
    assign port_latch_o              = state_q.plat;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    chk_vector_jump: assert property (
        wr && paddr_i == fetch_map_pkg::OFS_VECT && pwdata_i[2:0] == 3'h2
        && state_q.st == fetch_map_pkg::S_IDLE && !state_q.pend
        |=> state_q.pc == 16'h0013 && state_q.pend)
        else $error("vector address wrong");
    chk_int_rom_sel: assert property (
        state_q.st == fetch_map_pkg::S_IDLE && state_q.pend &&
        state_q.strap_s[1] && state_q.pc <= 16'h0FFF
        |=> state_q.st == fetch_map_pkg::S_INT ##1 !state_q.ext_src)
        else $error("internal fetch not taken");
    chk_ext_all: assert property (
        state_q.st == fetch_map_pkg::S_IDLE && state_q.pend &&
        !state_q.strap_s[1] |=> addr_latch_strobe_o ##6 state_q.ext_src)
        else $error("strap low fetch not external");
    chk_addr_phase: assert property (
        addr_latch_strobe_o |-> muxed_addr_data_port_oe_o &&
        muxed_addr_data_port_o == state_q.pc[7:0] ##1
        !addr_latch_strobe_o && muxed_addr_data_port_oe_o ##1
        !muxed_addr_data_port_oe_o && !code_read_strobe_n_o)
        else $error("address phase wrong");
    chk_strobe_float: assert property (
        !code_read_strobe_n_o |-> !muxed_addr_data_port_oe_o)
        else $error("port driven during strobe");
    chk_high_port: assert property (
        $fell(code_read_strobe_n_o) |-> (high_addr_port_o ==
        state_q.pc[15:8] && !code_read_strobe_n_o) [*4] ##1
        code_read_strobe_n_o) else $error("high byte or strobe wrong");
    chk_sp_push: assert property (
        wr && paddr_i == fetch_map_pkg::OFS_PUSH
        |=> state_q.sp == $past(state_q.sp) + 8'h01 &&
        state_q.ram[state_q.sp[6:0]] == $past(pwdata_i[7:0]))
        else $error("push wrong");
    chk_sfr_indirect: assert property (
        setup && paddr_i == fetch_map_pkg::OFS_DDAT && state_q.dadr[7] &&
        state_q.dadr[fetch_map_pkg::DA_IND] &&
        !state_q.dadr[fetch_map_pkg::DA_REG]
        |=> prdata_o == 32'h0000_0000) else $error("indirect hit special");
    chk_timer_count: assert property (
        state_q.trun[0] && !wr |=> {state_q.th0, state_q.tl0} ==
        $past({state_q.th0, state_q.tl0}) + 16'h0001)
        else $error("timer did not count");
endmodule // fetch_map
`default_nettype wire

// >>> core/fetch_map_pkg.sv
// Constants and types for the program-fetch and memory-map block.
// Assumes one 100 MHz core clock and an APB master on the same clock.
package fetch_map_pkg;
    // Code space layout
    localparam logic [15:0] RESET_PC    = 16'h0000;
    localparam logic [15:0] VEC_BASE    = 16'h0003;
    localparam logic [15:0] VEC_STEP    = 16'h0008;
    localparam logic [2:0]  VEC_COUNT   = 3'h5;
    localparam logic [15:0] INT_ROM_TOP = 16'h0FFF;
    // Data space layout and reset values
    localparam logic [7:0]  SP_RESET    = 8'h07;
    localparam logic [7:0]  PSW_RESET   = 8'h00;
    localparam logic [7:0]  PLAT_RESET  = 8'hFF;
    localparam int          PSW_BANK    = 3;
    localparam logic [7:0]  IP_USED     = 8'h1F;
    // Special function addresses
    localparam logic [7:0]  SFR_BASE    = 8'h80;
    localparam logic [7:0]  SFR_SP      = 8'h81;
    localparam logic [7:0]  SFR_DPL     = 8'h82;
    localparam logic [7:0]  SFR_DPH     = 8'h83;
    localparam logic [7:0]  SFR_TL0     = 8'h8A;
    localparam logic [7:0]  SFR_TL1     = 8'h8B;
    localparam logic [7:0]  SFR_TH0     = 8'h8C;
    localparam logic [7:0]  SFR_TH1     = 8'h8D;
    localparam logic [7:0]  SFR_PORT    = 8'h90;
    localparam logic [7:0]  SFR_IP      = 8'hB8;
    localparam logic [7:0]  SFR_PSW     = 8'hD0;
    // APB register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_FADDR   = 8'h04;
    localparam logic [7:0]  OFS_VECT    = 8'h08;
    localparam logic [7:0]  OFS_STAT    = 8'h0C;
    localparam logic [7:0]  OFS_DADR    = 8'h10;
    localparam logic [7:0]  OFS_DDAT    = 8'h14;
    localparam logic [7:0]  OFS_PUSH    = 8'h18;
    localparam logic [7:0]  OFS_DATA_POINTER_PAIR    = 8'h1C;
    localparam logic [7:0]  OFS_TIMR    = 8'h20;
    // Field positions
    localparam int          CTRL_START  = 0;
    localparam int          CTRL_TRUN   = 1;
    localparam int          DA_IND      = 8;
    localparam int          DA_BIT      = 9;
    localparam int          DA_REG      = 10;
    localparam int          DA_POS      = 11;
    // Strobe cycles before the code byte is sampled
    localparam logic [1:0]  STRB_WAIT   = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ALE  = 3'b001,
        S_ADR  = 3'b011,
        S_STB  = 3'b010,
        S_SMP  = 3'b110,
        S_INT  = 3'b100
    } fetch_state_t;
endpackage

// >>> test/ext_code_rom.sv
// Model of the external program ROM and its low-address latch.
// Assumes the bench resolves the shared muxed bus from both enables.
`timescale 1ns/100ps
`default_nettype none
module ext_code_rom (
    input  wire logic       clk_i,
    input  wire logic       latch_strobe_i,
    input  wire logic       code_read_strobe_n_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] bus_i,
    input  wire logic [7:0] high_i,
    output logic      [7:0] data_o,
    output logic            oe_o
);
    logic [7:0] low_q;
    logic       late_q;
    // Latch takes the low address while its strobe is high
    always_ff @(posedge clk_i) begin
        if (latch_strobe_i)
            low_q <= bus_i;
        late_q <= !code_read_strobe_n_i;
    end
    // Slow mode drives one cycle late, still inside the window
    assign oe_o   = !code_read_strobe_n_i && (!slow_i || late_q);
    // Byte hashes both halves, so a wrong high byte shows
    assign data_o = low_q ^ high_i ^ 8'h5A;
endmodule // ext_code_rom
`default_nettype wire

// >>> test/testbench.sv
// Bench for fetch_map: APB register tasks and an external code ROM.
// Assumes one clock; the bench resolves the muxed bus itself.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // Stimulus and observed signals
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, strap = 1'b0, slow = 1'b0, e, x;
    logic [7:0]  paddr = 8'h00, pins = 8'h96, last = 8'h00;
    logic [31:0] pwd = 32'h0000_0000, r, prd;
    logic [11:0] ra;
    logic [10:0] ex;
    logic [7:0]  mo, hi, xd, bus, pl;
    logic        prdy, perr, moe, ale, psn, xoe;
    int          mismatches = 0, num_checks = 0;
    logic [15:0] tab [6] = '{16'h0FFF, 16'h0FFF, 16'h1000, 16'h1000,
                             16'hA5C3, 16'h0123};
    always #5 clk = ~clk;
    // Undriven bus toggles, so a late sample never looks right
    assign bus = moe ? mo : (xoe ? xd : ~last);
    always @(posedge clk) begin
        last <= bus;
        if (moe && xoe)
            chk(1'b1, 1'b0);
    end
    fetch_map dut (
        .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .external_code_strap_i(strap),
        .rom_addr_o(ra), .rom_data_i(~ra[7:0] ^ {4'h0, ra[11:8]}),
        .muxed_addr_data_port_i(bus), .muxed_addr_data_port_o(mo),
        .muxed_addr_data_port_oe_o(moe), .addr_latch_strobe_o(ale),
        .code_read_strobe_n_o(psn), .high_addr_port_o(hi),
        .port_pin_i(pins), .port_latch_o(pl)
    );
    ext_code_rom rom (
        .clk_i(clk), .latch_strobe_i(ale), .code_read_strobe_n_i(psn),
        .slow_i(slow), .bus_i(bus), .high_i(hi), .data_o(xd), .oe_o(xoe)
    );
    // Expected code byte from either memory
    function automatic logic [7:0] code_b(input logic [15:0] a,
                                          input logic ext);
        return ext ? a[7:0] ^ a[15:8] ^ 8'h5A : ~a[7:0] ^ {4'h0, a[11:8]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the watchdog alone ends a wait for pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel  <= 1'b1;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, exp);
    endtask
    task automatic dwr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, fetch_map_pkg::OFS_DADR, {16'h0000, a});
        apb(1'b1, fetch_map_pkg::OFS_DDAT, {24'h00_0000, d});
    endtask
    task automatic drd(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, fetch_map_pkg::OFS_DADR, {16'h0000, a});
        rd(fetch_map_pkg::OFS_DDAT, {24'h00_0000, d});
    endtask
    // Poll the busy flag; leaves the last status word in r
    task automatic idle();
        for (int n = 0; n < 40; n++) begin
            apb(1'b0, fetch_map_pkg::OFS_STAT, 32'h0000_0000);
            if (r[8] === 1'b0)
                return;
        end
        mismatches++;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        chk({psn, moe}, 2'b10);
        rst <= 1'b0;
        idle();
        chk(r[9:0], {2'b10, code_b(16'h0000, 1'b1)});
        rd(fetch_map_pkg::OFS_PUSH, 32'h0000_0007);
        $display("test reset done");
        // Strap, speed and boundary addresses in one table
        for (int i = 0; i < 6; i++) begin
            strap <= i[0];
            slow  <= i[1];
            repeat (4) @(posedge clk);
            apb(1'b1, fetch_map_pkg::OFS_FADDR, {16'h0000, tab[i]});
            apb(1'b1, fetch_map_pkg::OFS_CTRL, 32'h0000_0001);
            idle();
            x  = !i[0] || tab[i] > 16'h0FFF;
            ex = {i[0], x, 1'b0, code_b(tab[i], x)};
            chk(r[10:0], ex);
        end
        strap <= 1'b0;
        repeat (4) @(posedge clk);
        // Index 5 is out of range and must leave the last byte
        for (int n = 0; n < 6; n++) begin
            apb(1'b1, fetch_map_pkg::OFS_VECT, 32'(n));
            idle();
            ex = {3'b010, code_b(16'h0003 + 16'(8 * (n > 4 ? 4 : n)), 1'b1)};
            chk(r[10:0], ex);
        end
        $display("test fetch done");
        apb(1'b1, fetch_map_pkg::OFS_PUSH, 32'h0000_00A5);
        rd(fetch_map_pkg::OFS_PUSH, 32'h0000_0008);
        drd(16'h0008, 8'hA5);
        dwr(16'h00D0, 8'h18);
        dwr(16'h0402, 8'h3C);
        drd(16'h001A, 8'h3C);
        apb(1'b1, fetch_map_pkg::OFS_DATA_POINTER_PAIR, 32'h0000_1234);
        drd(16'h0082, 8'h34);
        dwr(16'h0083, 8'h56);
        rd(fetch_map_pkg::OFS_DATA_POINTER_PAIR, 32'h0000_5634);
        dwr(16'h008A, 8'h11);
        dwr(16'h008C, 8'h22);
        apb(1'b0, fetch_map_pkg::OFS_TIMR, 32'h0000_0000);
        chk(r[15:0], 16'h2211);
        $display("test data done");
        dwr(16'h12B8, 8'h01);
        drd(16'h00B8, 8'h04);
        dwr(16'h00B8, 8'hFF);
        drd(16'h00B8, 8'h1F);
        dwr(16'h1281, 8'h01);
        drd(16'h0081, 8'h08);
        drd(16'h0090, 8'h96);
        drd(16'h0190, 8'h00);
        drd(16'h0084, 8'h00);
        dwr(16'h0090, 8'h3C);
        @(negedge clk);
        chk(pl, 8'h3C);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk(e, 1'b1);
        $display("test special done");
        stop_test();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        mismatches++;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
